//--- sdf_defines.vh
// Constants for the sigma-delta decimation filter and reference-detect block
`ifndef SDF_DEFINES_VH
`define SDF_DEFINES_VH
// Modulator sample tick: master clock divided by 16
`define SDF_MOD_DIV        4'hF
// Rate divider word width
`define SDF_SF_W           12
// Chop mode multiplies the decimation period by three
`define SDF_CHOP_MULT      2'h3
// Sinc3 accumulator width: 3*log2(3*4095*16)+1, rounded up
`define SDF_ACC_W          54
// Result width
`define SDF_RES_W          24
// Full-scale result returned when the reference is missing
`define SDF_ALL_ONES       24'hFFFFFF
// Step threshold as a result delta (1 percent of full scale)
`define SDF_STEP_THR       24'h028F5C
// Moving-average length after a step, then back to FIR
`define SDF_AVG_LEN        5'h16
// FIR taps
`define SDF_TAPS           22
`define SDF_TAP_IDX_W      5
// Centre tap index and last tap index of the symmetric window
`define SDF_TAP_MID        5'h0B
`define SDF_TAP_LAST       5'h15
// Second stage modes
`define SDF_S2_FIR         2'h0
`define SDF_S2_BYPASS      2'h1
// Calibration kinds
`define SDF_CAL_NONE       2'h0
`define SDF_CAL_OFFSET     2'h1
`define SDF_CAL_GAIN       2'h2
`endif

//--- sdf_filter.v
// Sinc3 decimator, second-stage FIR/step averager and reference-detect handling
`timescale 1ns/10ps
`include "sdf_defines.vh"

module sdf_filter
(
  // Clock and reset
  input  wire                    clk_in,
  input  wire                    rstn_in,
  // Modulator and reference comparator
  input  wire                    mod_bit_in,
  input  wire                    ref_low_in,
  input  wire                    ref_open_in,
  // Configuration
  input  wire [`SDF_SF_W-1:0]    rate_divider_word_in,
  input  wire                    chop_enable_in,
  input  wire                    high_reference_mode_in,
  input  wire                    ac_mode_in,
  input  wire                    step_enable_in,
  input  wire                    bypass_in,
  // Calibration request
  input  wire [1:0]              cal_kind_in,
  input  wire                    cal_start_in,
  // Results
  output reg  [`SDF_RES_W-1:0]   data_out,
  output reg                     data_valid_out,
  output reg  [`SDF_RES_W-1:0]   offset_coef_out,
  output reg  [`SDF_RES_W-1:0]   gain_coef_out,
  output reg                     cal_done_out,
  // Status
  output wire                    missing_reference_flag_alt_out,
  output reg                     step_active_out,
  output reg                     excitation_phase_outputs_out
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Absolute difference of two results, used by the step detector
  function [`SDF_RES_W-1:0] absdiff;
    input [`SDF_RES_W-1:0] a;
    input [`SDF_RES_W-1:0] b;
    begin
      absdiff = (a > b) ? (a - b) : (b - a);
    end
  endfunction

  // Fixed symmetric low-pass window, weights 1..11..1 (sum 132)
  function [3:0] fir_coef;
    input [`SDF_TAP_IDX_W-1:0] idx;
    reg   [`SDF_TAP_IDX_W-1:0] mirror;
    begin
      mirror   = `SDF_TAP_LAST - idx;
      fir_coef = (idx < `SDF_TAP_MID) ? (idx[3:0] + 4'h1) : (mirror[3:0] + 4'h1);
    end
  endfunction

  // ---------------------------------------------------------------
  // Reference detect
  // ---------------------------------------------------------------
  // Comparator outputs are synchronous; flag follows them directly
  assign missing_reference_flag_alt_out = ref_low_in | ref_open_in;

  // ---------------------------------------------------------------
  // Modulator sample tick
  // ---------------------------------------------------------------
  reg  [3:0]                 mod_cnt;
  wire                       mod_tick = (mod_cnt == `SDF_MOD_DIV);

  // Divide by 16: 4.9152 MHz gives the 307 kHz modulator rate
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      mod_cnt <= 4'h0;
    else
      mod_cnt <= mod_cnt + 4'h1;
  end

  // ---------------------------------------------------------------
  // Decimation counter
  // ---------------------------------------------------------------
  // Chop needs three times the modulator periods per word for full settling
  wire [13:0] dec_len = chop_enable_in ?
                        ({2'h0, rate_divider_word_in} * {12'h0, `SDF_CHOP_MULT})
                        : {2'h0, rate_divider_word_in};
  reg  [13:0]                dec_cnt;
  wire                       dec_done = mod_tick && (dec_cnt + 14'h1 >= dec_len);

  // Divider zero is treated as one to avoid a stalled chain
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      dec_cnt <= 14'h0;
    else if (dec_done)
      dec_cnt <= 14'h0;
    else if (mod_tick)
      dec_cnt <= dec_cnt + 14'h1;
  end

  // ---------------------------------------------------------------
  // Chop phase and excitation drive
  // ---------------------------------------------------------------
  // Phase toggles each first-stage word in chop or ac mode; drives the excitation switch
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      excitation_phase_outputs_out <= 1'b0;
    else if (dec_done && (chop_enable_in || ac_mode_in))
      excitation_phase_outputs_out <= ~excitation_phase_outputs_out;
  end

  // ---------------------------------------------------------------
  // Sinc3 first stage
  // ---------------------------------------------------------------
  reg  [`SDF_ACC_W-1:0] int1, int2, int3, dif1, dif2, dif3;
  wire [`SDF_ACC_W-1:0] d1 = int3 - dif1;
  wire [`SDF_ACC_W-1:0] d2 = d1 - dif2;
  wire [`SDF_ACC_W-1:0] d3 = d2 - dif3;
  wire [`SDF_ACC_W-1:0] samp = {{(`SDF_ACC_W-1){1'b0}}, mod_bit_in};

  // Integrators at modulator rate, combs at output rate
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      int1 <= {`SDF_ACC_W{1'b0}};
      int2 <= {`SDF_ACC_W{1'b0}};
      int3 <= {`SDF_ACC_W{1'b0}};
      dif1 <= {`SDF_ACC_W{1'b0}};
      dif2 <= {`SDF_ACC_W{1'b0}};
      dif3 <= {`SDF_ACC_W{1'b0}};
    end
    else
    begin
      if (mod_tick)
      begin
        int1 <= int1 + samp;
        int2 <= int2 + int1;
        int3 <= int3 + int2;
      end
      if (dec_done)
      begin
        dif1 <= int3;
        dif2 <= d1;
        dif3 <= d2;
      end
    end
  end

  // Normalise by the divider word cubed is costly; take the low bits.
  // Limitation: gain depends on divider, calibration absorbs it.
  wire [`SDF_RES_W-1:0] s1_raw = d3[`SDF_RES_W-1:0];
  // Demodulate chop: odd phases carry a reversed input and reference
  wire                  s1_flip = (chop_enable_in || ac_mode_in) && excitation_phase_outputs_out;
  wire [`SDF_RES_W-1:0] s1_word = s1_flip ? ~s1_raw : s1_raw;
  // Low reference without high-reference scaling halves ranges: arithmetic shift right by one, halving the word
  wire [`SDF_RES_W-1:0] s1_out = high_reference_mode_in ? s1_word
                                 : {s1_word[`SDF_RES_W-1], s1_word[`SDF_RES_W-1:1]};

  // ---------------------------------------------------------------
  // Second stage: FIR, step averager, bypass
  // ---------------------------------------------------------------
  reg  [`SDF_RES_W-1:0]   taps [0:`SDF_TAPS-1];
  reg  [`SDF_RES_W-1:0]   prev1, prev2;
  reg  [4:0]              avg_cnt;
  reg  [`SDF_RES_W+4:0]   avg_sum;
  reg  [`SDF_RES_W+7:0]   fir_acc;
  reg  [`SDF_RES_W-1:0]   s2_res;
  integer                 i;
  integer                 j;
  // Divide the whole sum so long averages keep their top bits
  wire [`SDF_RES_W+4:0]   avg_quot = avg_sum / {{(`SDF_RES_W){1'b0}}, avg_cnt + 5'h1};

  // FIR sum over the delay line, normalised by 128 (close to 132)
  always @*
  begin
    fir_acc = {(`SDF_RES_W+8){1'b0}};
    for (i = 0; i < `SDF_TAPS; i = i + 1)
      fir_acc = fir_acc + taps[i] * fir_coef(i[4:0]);
  end

  // Step: compare with the word two back, as the settling lag dictates
  wire step_hit = step_enable_in && (absdiff(s1_out, prev2) > `SDF_STEP_THR);

  always @*
  begin
    if (bypass_in)
      s2_res = s1_out;
    else if (step_active_out)
      s2_res = avg_quot[`SDF_RES_W-1:0];
    else
      s2_res = fir_acc[`SDF_RES_W+6:7];
  end

  // Delay line and averager bookkeeping
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      for (j = 0; j < `SDF_TAPS; j = j + 1)
        taps[j] <= {`SDF_RES_W{1'b0}};
      prev1           <= {`SDF_RES_W{1'b0}};
      prev2           <= {`SDF_RES_W{1'b0}};
      avg_cnt         <= 5'h0;
      avg_sum         <= {(`SDF_RES_W+5){1'b0}};
      step_active_out <= 1'b0;
    end
    else if (dec_done)
    begin
      taps[0] <= s1_out;
      for (j = 1; j < `SDF_TAPS; j = j + 1)
        taps[j] <= taps[j-1];
      prev1 <= s1_out;
      prev2 <= prev1;
      if (step_hit)
      begin
        // Restart averaging from the new level
        step_active_out <= 1'b1;
        avg_cnt         <= 5'h0;
        avg_sum         <= {5'h0, s1_out};
      end
      else if (step_active_out)
      begin
        if (avg_cnt == `SDF_AVG_LEN)
          step_active_out <= 1'b0;
        else
        begin
          avg_cnt <= avg_cnt + 5'h1;
          avg_sum <= avg_sum + {5'h0, s1_out};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Result register and calibration
  // ---------------------------------------------------------------
  reg  [1:0] cal_kind;
  reg        cal_ref_bad;

  // Conversion or calibration word lands one cycle after each decimation
  always @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      data_out        <= {`SDF_RES_W{1'b0}};
      data_valid_out  <= 1'b0;
      offset_coef_out <= {`SDF_RES_W{1'b0}};
      gain_coef_out   <= {`SDF_RES_W{1'b0}};
      cal_done_out    <= 1'b0;
      cal_kind        <= `SDF_CAL_NONE;
      cal_ref_bad     <= 1'b0;
    end
    else
    begin
      data_valid_out <= 1'b0;
      cal_done_out   <= 1'b0;
      if (cal_start_in && cal_kind_in != `SDF_CAL_NONE)
      begin
        cal_kind    <= cal_kind_in;
        cal_ref_bad <= missing_reference_flag_alt_out;
      end
      else if (cal_kind != `SDF_CAL_NONE)
      begin
        // Any missing reference during the calibration poisons it
        if (dec_done)
        begin
          if (!(cal_ref_bad || missing_reference_flag_alt_out))
          begin
            if (cal_kind == `SDF_CAL_OFFSET)
              offset_coef_out <= s2_res;
            else
              gain_coef_out <= s2_res;
          end
          cal_kind     <= `SDF_CAL_NONE;
          cal_done_out <= 1'b1;
        end
        else if (missing_reference_flag_alt_out)
          cal_ref_bad <= 1'b1;
      end
      else if (dec_done)
      begin
        data_out       <= missing_reference_flag_alt_out ? `SDF_ALL_ONES : s2_res;
        data_valid_out <= 1'b1;
      end
    end
  end

endmodule

//--- sdf_filter_props.sv
// Port-level assertions for the decimation filter block
`timescale 1ns/10ps
module sdf_filter_props
(
  // Inputs watched
  input wire        clk_in,
  input wire        rstn_in,
  input wire        ref_low_in,
  input wire        ref_open_in,
  input wire        chop_enable_in,
  input wire        ac_mode_in,
  // Outputs watched
  input wire [23:0] data_out,
  input wire        data_valid_out,
  input wire [23:0] offset_coef_out,
  input wire [23:0] gain_coef_out,
  input wire        cal_done_out,
  input wire        missing_reference_flag_alt_out,
  input wire        excitation_phase_outputs_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Flag, result, coefficient and excitation phase relations
  flag_follow_a: assert property (missing_reference_flag_alt_out == (ref_low_in | ref_open_in))
    else $error("flag not tracking faults");
  ones_missing_reference_flag_alt_a: assert property (data_valid_out && $past(missing_reference_flag_alt_out)
    |-> data_out == 24'hFFFFFF) else $error("missing all ones");
  valid_space_a: assert property (data_valid_out |=> !data_valid_out [*8])
    else $error("results too close");
  data_hold_a: assert property (!data_valid_out |-> $stable(data_out))
    else $error("result moved without valid");
  offset_keep_a: assert property (cal_done_out && $past(missing_reference_flag_alt_out)
    |-> $stable(offset_coef_out)) else $error("offset written on fault");
  gain_keep_a: assert property (cal_done_out && $past(missing_reference_flag_alt_out)
    |-> $stable(gain_coef_out)) else $error("gain written on fault");
  coef_quiet_a: assert property (!cal_done_out |-> $stable(offset_coef_out)
    && $stable(gain_coef_out)) else $error("coefficient moved");
  exc_dc_a: assert property (!chop_enable_in && !ac_mode_in && !$past(chop_enable_in)
    && !$past(ac_mode_in)
    |-> $stable(excitation_phase_outputs_out)) else $error("phase toggled in dc");
  // Main scenarios seen
  cv_valid: cover property (data_valid_out);
  cv_cal: cover property (cal_done_out);
  cv_ones: cover property (data_valid_out && data_out == 24'hFFFFFF);
endmodule
bind sdf_filter sdf_filter_props u_props (.clk_in(clk_in), .rstn_in(rstn_in),
  .ref_low_in(ref_low_in), .ref_open_in(ref_open_in), .chop_enable_in(chop_enable_in),
  .ac_mode_in(ac_mode_in), .data_out(data_out), .data_valid_out(data_valid_out),
  .offset_coef_out(offset_coef_out), .gain_coef_out(gain_coef_out),
  .cal_done_out(cal_done_out), .missing_reference_flag_alt_out(missing_reference_flag_alt_out),
  .excitation_phase_outputs_out(excitation_phase_outputs_out));

//--- sdf_mod_model.sv
// Modulator bitstream and reference comparator model
`timescale 1ns/10ps
module sdf_mod_model
(
  // Clock and reset
  input  wire       clk_in,
  input  wire       rstn_in,
  // Scenario controls
  input  wire [8:0] level_in,
  input  wire       fault_low_in,
  input  wire       fault_open_in,
  // Toward the filter
  output reg        mod_bit_out,
  output reg        ref_low_out,
  output reg        ref_open_out
);
  reg [7:0] acc;
  // First-order loop, ones density is level_in/256; 256 gives solid ones
  always @(posedge clk_in or negedge rstn_in)
    if (!rstn_in)
    begin
      acc <= 8'h00;
      mod_bit_out <= 1'b0;
    end
    else
      {mod_bit_out, acc} <= {1'b0, acc} + level_in;
  // Comparator raises its fault lines as commanded
  always @(posedge clk_in)
  begin
    ref_low_out <= fault_low_in;
    ref_open_out <= fault_open_in;
  end
endmodule

//--- sdf_filter_tb_top.sv
// Self-checking bench for the decimation filter block
`timescale 1ns/10ps
`include "sdf_defines.vh"
module sdf_filter_tb_top;
  reg         clk_in = 1'b0;
  reg         rstn_in = 1'b0;
  reg  [11:0] sf = 12'h003;
  reg         chop = 1'b0, high_reference_mode = 1'b1, acm = 1'b0, stp = 1'b0, byp = 1'b1, cst = 1'b0;
  reg  [1:0]  kind = 2'h0;
  reg  [8:0]  level = 9'h100;
  reg         f_low = 1'b0, f_open = 1'b0;
  wire        mbit, rlow, ropen, dv, cdone, flag, exc, sact;
  wire [23:0] dat, ocoef, gcoef;
  integer     fails = 0, checks_done = 0, k;
  // Clock, 25 ns period
  always #12.5 clk_in = ~clk_in;
  sdf_mod_model MOD (.clk_in(clk_in), .rstn_in(rstn_in), .level_in(level),
    .fault_low_in(f_low), .fault_open_in(f_open), .mod_bit_out(mbit),
    .ref_low_out(rlow), .ref_open_out(ropen));
  sdf_filter DUT (.clk_in(clk_in), .rstn_in(rstn_in), .mod_bit_in(mbit), .ref_low_in(rlow),
    .ref_open_in(ropen), .rate_divider_word_in(sf), .chop_enable_in(chop),
    .high_reference_mode_in(high_reference_mode), .ac_mode_in(acm), .step_enable_in(stp), .bypass_in(byp),
    .cal_kind_in(kind), .cal_start_in(cst), .data_out(dat), .data_valid_out(dv),
    .offset_coef_out(ocoef), .gain_coef_out(gcoef), .cal_done_out(cdone),
    .missing_reference_flag_alt_out(flag), .step_active_out(sact),
    .excitation_phase_outputs_out(exc));
  task complete_run;
  begin
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task chk(input ok, input string msg);
  begin
    checks_done = checks_done + 1;
    if (ok !== 1'b1)
    begin
      fails = fails + 1;
      $display("mismatch at %0t: %s", $time, msg);
    end
  end
  endtask
  // Bounded wait for a valid (sel 0) or calibration done (sel 1); returns at a falling edge
  task wait_ev(input sel);
    integer i;
  begin
    i = 0;
    @(posedge clk_in);
    @(negedge clk_in);
    while ((sel ? cdone : dv) !== 1'b1 && i < 4000)
    begin
      @(negedge clk_in);
      i = i + 1;
    end
    if (i >= 4000)
    begin
      chk(1'b0, "wait ran out");
      complete_run;
    end
  end
  endtask
  // Interval between results
  task t_rate(input c);
    time t0;
  begin
    @(posedge clk_in);
    #1 chop = c;
    for (k = 0; k < 4; k = k + 1) wait_ev(0);
    t0 = $time;
    wait_ev(0);
    chk(($time - t0) == (c ? 48 : 16) * sf * 25, "result interval");
  end
  endtask
  // Solid ones settle to the sinc3 gain, halved under low reference scaling
  task t_level(input h);
  begin
    @(posedge clk_in);
    #1 high_reference_mode = h;
    chop = 1'b0;
    for (k = 0; k < 5; k = k + 1) wait_ev(0);
    chk(dat === (h ? sf * sf * sf : (sf * sf * sf) >> 1), "steady word");
  end
  endtask
  // Reference faults force all ones
  task t_missing_reference_flag_alt(input o);
  begin
    @(posedge clk_in);
    #1 f_low = !o;
    f_open = o;
    wait_ev(0);
    wait_ev(0);
    chk(flag === 1'b1, "flag low on fault");
    chk(dat === 24'hFFFFFF, "result not all ones");
  end
  endtask
  // Calibration of the given kind; fault expected means coefficients stay zero
  task t_cal(input [1:0] kd, input flt);
  begin
    @(posedge clk_in);
    #1 f_open = flt;
    byp = 1'b1;
    // Comparator output lags one clock, so the fault settles before the start
    @(posedge clk_in);
    #1 kind = kd;
    cst = 1'b1;
    @(posedge clk_in);
    #1 cst = 1'b0;
    wait_ev(1);
    chk(flag === flt, "flag after calibration");
    chk(flt ? (ocoef === 24'h0 && gcoef === 24'h0)
      : ((kd == 2'h1 ? ocoef : gcoef) === sf * sf * sf), "coefficient");
  end
  endtask
  // Ac mode: phase toggles per word and odd words come out inverted
  task t_ac;
    reg [23:0] w0;
    reg        p0;
  begin
    @(posedge clk_in);
    #1 acm = 1'b1;
    high_reference_mode = 1'b1;
    wait_ev(0);
    wait_ev(0);
    w0 = dat;
    p0 = exc;
    wait_ev(0);
    chk(exc !== p0, "phase not alternating");
    chk(dat === ~w0, "word not inverted on odd phase");
  end
  endtask
  // Leaving ac mode is a large step: average of steady words, then back to FIR
  task t_step;
  begin
    @(posedge clk_in);
    #1 acm = 1'b0;
    byp = 1'b0;
    stp = 1'b1;
    for (k = 0; k < 4; k = k + 1) wait_ev(0);
    chk(sact === 1'b1, "no averaging after step");
    chk(dat === sf * sf * sf, "average of steady words");
    for (k = 0; k < 26; k = k + 1) wait_ev(0);
    chk(sact === 1'b0, "averaging did not end");
    // Window weights sum to 132, normalised by 128
    chk(dat === ((sf * sf * sf * 132) >> 7), "fir steady word");
  end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_in);
    #1 rstn_in = 1'b1;
    t_rate(1'b0);
    t_rate(1'b1);
    t_level(1'b1);
    t_level(1'b0);
    t_ac;
    t_step;
    t_missing_reference_flag_alt(1'b0);
    t_missing_reference_flag_alt(1'b1);
    t_cal(2'h1, 1'b1);
    t_cal(2'h2, 1'b1);
    t_cal(2'h1, 1'b0);
    t_cal(2'h2, 1'b0);
    complete_run;
  end
endmodule
